//--- rtpc_pkg.sv
// constants for the radio test and pin configuration register bank
// Operation
// - calibration field resets to 1, calibrating on each transition; 0xF skips calibration.
// - test pin three shows signal strength only with probe select 0x64 and probe mux 0x3.
// - pin function resets to 0x00 (default); 0x21 puts the raw slicer on general pin five.
// - 0x40 puts limiter Q, I on pins 0, 1; 0x41 filtered there and unfiltered on pins 2, 3.
// - pin function 0x50 puts packet transmit data from the processor on general pin zero.
// - pin function 0x53 puts the amplifier ramp finished indication on general pin zero.
// - transmit mode 0 normal, 2 continuous preamble, 3 continuous carrier, others reserved.
// - crystal config bits five to three hold tuning code; other bits reserved, written 0.
// - two read-only registers hold last calibration band and amplitude, zero after reset.
package rtpc_pkg;
    localparam logic [9:0] ADDR_TX_TEST_MODE = 10'h00D;
    localparam logic [9:0] ADDR_CAL_CTRL = 10'h3D0;
    localparam logic [9:0] ADDR_XTAL_CFG = 10'h3D2;
    localparam logic [9:0] ADDR_BAND_RES = 10'h3DA;
    localparam logic [9:0] ADDR_AMPL_RES = 10'h3DB;
    localparam logic [9:0] ADDR_PROBE_SEL = 10'h3F8;
    localparam logic [9:0] ADDR_PROBE_MUX = 10'h3F9;
    localparam logic [9:0] ADDR_PIN_FUNC = 10'h3FA;
    localparam logic [9:0] ADDR_DAC_GAIN = 10'h3FD;

    localparam logic [3:0] RST_CAL_CTRL = 4'h1;
    localparam logic [3:0] CAL_BYPASS = 4'hF;
    localparam logic [2:0] RST_XTAL_CODE = 3'h0;
    localparam int XTAL_CODE_LSB = 3;
    localparam int XTAL_CODE_MSB = 5;
    localparam logic [7:0] RST_PROBE_SEL = 8'h00;
    localparam logic [7:0] PROBE_SEL_RSSI = 8'h64;
    localparam logic [1:0] RST_PROBE_MUX = 2'h0;
    localparam logic [1:0] PROBE_MUX_RSSI = 2'h3;
    localparam logic [7:0] RST_PIN_FUNC = 8'h00;
    localparam logic [3:0] RST_DAC_GAIN = 4'h4;
    localparam logic [7:0] RST_TX_TEST_MODE = 8'h00;
    localparam logic [7:0] RST_RESULT = 8'h00;

    localparam logic [7:0] PF_DEFAULT = 8'h00;
    localparam logic [7:0] PF_SLICER = 8'h21;
    localparam logic [7:0] PF_LIMITER = 8'h40;
    localparam logic [7:0] PF_LIMITER_FILT = 8'h41;
    localparam logic [7:0] PF_TX_DATA = 8'h50;
    localparam logic [7:0] PF_PA_RAMP = 8'h53;
    localparam logic [3:0] PF_SPORT_HI = 4'hA;
    localparam logic [3:0] PF_SPORT_MAX = 4'h8;
    localparam logic [7:0] PF_TEST_DAC = 8'hC9;

    localparam logic [7:0] TXM_NORMAL = 8'h00;
    localparam logic [7:0] TXM_PREAMBLE = 8'h02;
    localparam logic [7:0] TXM_CARRIER = 8'h03;

    typedef enum logic [1:0] {
        RTPC_TX_NORMAL,
        RTPC_TX_PREAMBLE,
        RTPC_TX_CARRIER,
        RTPC_TX_RESERVED
    } rtpc_tx_mode_t;
endpackage

//--- rtpc_regs.sv
// register bank for synthesizer calibration, crystal tuning, probes and pin functions
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ns
module rtpc_regs (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic [9:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_cal_done,
    input wire logic [7:0] i_cal_band,
    input wire logic [7:0] i_cal_ampl,
    input wire logic i_slicer_raw,
    input wire logic i_lim_q,
    input wire logic i_lim_i,
    input wire logic i_lim_q_filt,
    input wire logic i_lim_i_filt,
    input wire logic i_tx_data,
    input wire logic i_pa_ramp_done,
    input wire logic i_test_dac,
    input wire logic i_pin_default0,
    input wire logic i_pin_default1,
    input wire logic i_pin_default2,
    input wire logic i_pin_default3,
    input wire logic i_pin_default5,
    output logic o_cal_enable,
    output logic [2:0] o_crystal_tuning_code,
    output logic o_rssi_to_probe_pin,
    output logic [3:0] o_probe_gain,
    output logic [1:0] o_tx_test_mode,
    output logic o_sport_enable,
    output logic [3:0] o_sport_mode,
    output logic o_general_pin_zero,
    output logic o_general_pin_one,
    output logic o_general_pin_two,
    output logic o_interrupt_shared_pin_three,
    output logic o_general_pin_five
);
    logic [3:0] cal_ctrl_r;
    logic [2:0] xtal_code_r;
    logic [7:0] band_res_r;
    logic [7:0] ampl_res_r;
    logic [7:0] probe_sel_r;
    logic [1:0] probe_mux_r;
    logic [7:0] pin_func_r;
    logic [3:0] dac_gain_r;
    logic [7:0] tx_mode_r;
    logic [7:0] rdata_nxt;
    logic [1:0] s0_r;
    logic [1:0] s1_r;
    logic [1:0] s2_r;
    logic [1:0] s3_r;
    logic [1:0] s5_r;
    logic pin0_nxt;
    logic pin1_nxt;
    logic pin2_nxt;
    logic pin3_nxt;
    logic pin5_nxt;
    logic sport_sel;
    rtpc_pkg::rtpc_tx_mode_t tx_mode_nxt;

    // readback offsets have no write path
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            cal_ctrl_r <= rtpc_pkg::RST_CAL_CTRL;
        end else if (i_wr && (i_addr == rtpc_pkg::ADDR_CAL_CTRL)) begin
            cal_ctrl_r <= i_wdata[3:0];
        end
    end

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            xtal_code_r <= rtpc_pkg::RST_XTAL_CODE;
        end else if (i_wr && (i_addr == rtpc_pkg::ADDR_XTAL_CFG)) begin
            xtal_code_r <= i_wdata[rtpc_pkg::XTAL_CODE_MSB:rtpc_pkg::XTAL_CODE_LSB];
        end
    end

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            probe_sel_r <= rtpc_pkg::RST_PROBE_SEL;
        end else if (i_wr && (i_addr == rtpc_pkg::ADDR_PROBE_SEL)) begin
            probe_sel_r <= i_wdata;
        end
    end

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            probe_mux_r <= rtpc_pkg::RST_PROBE_MUX;
        end else if (i_wr && (i_addr == rtpc_pkg::ADDR_PROBE_MUX)) begin
            probe_mux_r <= i_wdata[1:0];
        end
    end

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            pin_func_r <= rtpc_pkg::RST_PIN_FUNC;
        end else if (i_wr && (i_addr == rtpc_pkg::ADDR_PIN_FUNC)) begin
            pin_func_r <= i_wdata;
        end
    end

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            dac_gain_r <= rtpc_pkg::RST_DAC_GAIN;
        end else if (i_wr && (i_addr == rtpc_pkg::ADDR_DAC_GAIN)) begin
            dac_gain_r <= i_wdata[3:0];
        end
    end

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            tx_mode_r <= rtpc_pkg::RST_TX_TEST_MODE;
        end else if (i_wr && (i_addr == rtpc_pkg::ADDR_TX_TEST_MODE)) begin
            tx_mode_r <= i_wdata;
        end
    end

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            band_res_r <= rtpc_pkg::RST_RESULT;
            ampl_res_r <= rtpc_pkg::RST_RESULT;
        end else if (i_cal_done) begin
            band_res_r <= i_cal_band;
            ampl_res_r <= i_cal_ampl;
        end
    end

    always_comb begin
        rdata_nxt = 8'h00;
        unique case (i_addr)
            rtpc_pkg::ADDR_CAL_CTRL: rdata_nxt = {4'h0, cal_ctrl_r};
            rtpc_pkg::ADDR_XTAL_CFG: rdata_nxt = {2'h0, xtal_code_r, 3'h0};
            rtpc_pkg::ADDR_BAND_RES: rdata_nxt = band_res_r;
            rtpc_pkg::ADDR_AMPL_RES: rdata_nxt = ampl_res_r;
            rtpc_pkg::ADDR_PROBE_SEL: rdata_nxt = probe_sel_r;
            rtpc_pkg::ADDR_PROBE_MUX: rdata_nxt = {6'h00, probe_mux_r};
            rtpc_pkg::ADDR_PIN_FUNC: rdata_nxt = pin_func_r;
            rtpc_pkg::ADDR_DAC_GAIN: rdata_nxt = {4'h0, dac_gain_r};
            rtpc_pkg::ADDR_TX_TEST_MODE: rdata_nxt = tx_mode_r;
            default: rdata_nxt = 8'h00;
        endcase
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            o_rdata <= rdata_nxt;
        end else begin
            o_rdata <= 8'h00;
        end
    end

    // two-flop synchronisers for pin-bound asynchronous signals
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            s0_r <= 2'h0;
        end else begin
            s0_r <= {s0_r[0], i_lim_q};
        end
    end

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            s1_r <= 2'h0;
        end else begin
            s1_r <= {s1_r[0], i_lim_i};
        end
    end

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            s2_r <= 2'h0;
        end else begin
            s2_r <= {s2_r[0], i_lim_q_filt};
        end
    end

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            s3_r <= 2'h0;
        end else begin
            s3_r <= {s3_r[0], i_lim_i_filt};
        end
    end

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            s5_r <= 2'h0;
        end else begin
            s5_r <= {s5_r[0], i_slicer_raw};
        end
    end

    assign sport_sel = (pin_func_r[7:4] == rtpc_pkg::PF_SPORT_HI)
        && (pin_func_r[3:0] <= rtpc_pkg::PF_SPORT_MAX);

    // pin multiplexer
    always_comb begin
        pin0_nxt = i_pin_default0;
        pin1_nxt = i_pin_default1;
        pin2_nxt = i_pin_default2;
        pin3_nxt = i_pin_default3;
        pin5_nxt = i_pin_default5;
        unique case (pin_func_r)
            rtpc_pkg::PF_SLICER: pin5_nxt = s5_r[1];
            rtpc_pkg::PF_LIMITER: begin
                pin0_nxt = s0_r[1];
                pin1_nxt = s1_r[1];
            end
            rtpc_pkg::PF_LIMITER_FILT: begin
                pin0_nxt = s2_r[1];
                pin1_nxt = s3_r[1];
                pin2_nxt = s0_r[1];
                pin3_nxt = s1_r[1];
            end
            rtpc_pkg::PF_TX_DATA: pin0_nxt = i_tx_data;
            rtpc_pkg::PF_PA_RAMP: pin0_nxt = i_pa_ramp_done;
            rtpc_pkg::PF_TEST_DAC: pin0_nxt = i_test_dac;
            default: ;
        endcase
    end

    always_comb begin
        unique case (tx_mode_r)
            rtpc_pkg::TXM_NORMAL: tx_mode_nxt = rtpc_pkg::RTPC_TX_NORMAL;
            rtpc_pkg::TXM_PREAMBLE: tx_mode_nxt = rtpc_pkg::RTPC_TX_PREAMBLE;
            rtpc_pkg::TXM_CARRIER: tx_mode_nxt = rtpc_pkg::RTPC_TX_CARRIER;
            default: tx_mode_nxt = rtpc_pkg::RTPC_TX_RESERVED;
        endcase
    end

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            o_cal_enable <= (rtpc_pkg::RST_CAL_CTRL != rtpc_pkg::CAL_BYPASS);
        end else begin
            o_cal_enable <= (cal_ctrl_r != rtpc_pkg::CAL_BYPASS);
        end
    end

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            o_crystal_tuning_code <= rtpc_pkg::RST_XTAL_CODE;
        end else begin
            o_crystal_tuning_code <= xtal_code_r;
        end
    end

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            o_rssi_to_probe_pin <= 1'b0;
        end else begin
            o_rssi_to_probe_pin <= (probe_sel_r == rtpc_pkg::PROBE_SEL_RSSI)
                && (probe_mux_r == rtpc_pkg::PROBE_MUX_RSSI);
        end
    end

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            o_probe_gain <= rtpc_pkg::RST_DAC_GAIN;
        end else begin
            o_probe_gain <= dac_gain_r;
        end
    end

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            o_tx_test_mode <= rtpc_pkg::RTPC_TX_NORMAL;
        end else begin
            o_tx_test_mode <= tx_mode_nxt;
        end
    end

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            o_sport_enable <= 1'b0;
        end else begin
            o_sport_enable <= sport_sel;
        end
    end

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            o_sport_mode <= 4'h0;
        end else begin
            o_sport_mode <= sport_sel ? pin_func_r[3:0] : 4'h0;
        end
    end

    // registered pin outputs
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            o_general_pin_zero <= 1'b0;
        end else begin
            o_general_pin_zero <= pin0_nxt;
        end
    end

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            o_general_pin_one <= 1'b0;
        end else begin
            o_general_pin_one <= pin1_nxt;
        end
    end

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            o_general_pin_two <= 1'b0;
        end else begin
            o_general_pin_two <= pin2_nxt;
        end
    end

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            o_interrupt_shared_pin_three <= 1'b0;
        end else begin
            o_interrupt_shared_pin_three <= pin3_nxt;
        end
    end

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            o_general_pin_five <= 1'b0;
        end else begin
            o_general_pin_five <= pin5_nxt;
        end
    end
endmodule // rtpc_regs

//--- rtpc_regs_sva.sv
// concurrent checks on the register bank ports
`timescale 1ns/1ns
module rtpc_regs_sva (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic [9:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic i_pa_ramp_done,
    input wire logic o_cal_enable,
    input wire logic [2:0] o_crystal_tuning_code,
    input wire logic o_rssi_to_probe_pin,
    input wire logic [3:0] o_probe_gain,
    input wire logic [1:0] o_tx_test_mode,
    input wire logic o_sport_enable,
    input wire logic [3:0] o_sport_mode,
    input wire logic o_general_pin_zero
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_reset);
    wire w_pin = i_wr && i_addr == rtpc_pkg::ADDR_PIN_FUNC;
    wire w_sel = i_wr && i_addr == rtpc_pkg::ADDR_PROBE_SEL;
    rd_idle_zero_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data not zero outside read slot");
    rd_unmapped_a: assert property (i_rd && i_addr == 10'h3FF |=> o_rdata == 8'h00)
        else $error("unmapped read not zero");
    cal_skip_a: assert property (i_wr && i_addr == rtpc_pkg::ADDR_CAL_CTRL |-> ##2
        o_cal_enable == (($past(i_wdata, 2) & 8'h0F) != 8'h0F)) else $error("cal enable wrong");
    xtal_code_a: assert property (i_wr && i_addr == rtpc_pkg::ADDR_XTAL_CFG |-> ##2
        o_crystal_tuning_code == 3'($past(i_wdata, 2) >> 3)) else $error("tuning code wrong");
    probe_gain_a: assert property (i_wr && i_addr == rtpc_pkg::ADDR_DAC_GAIN |-> ##2
        o_probe_gain == 4'($past(i_wdata, 2))) else $error("probe gain wrong");
    tx_carrier_a: assert property (i_wr && i_addr == rtpc_pkg::ADDR_TX_TEST_MODE
        && i_wdata == rtpc_pkg::TXM_CARRIER |-> ##2 o_tx_test_mode == 2'h2)
        else $error("carrier mode not selected");
    rssi_off_a: assert property (w_sel && i_wdata != rtpc_pkg::PROBE_SEL_RSSI |-> ##2
        !o_rssi_to_probe_pin) else $error("signal strength probe on wrongly");
    sport_mode_a: assert property (w_pin && i_wdata[7:4] == 4'hA && i_wdata[3:0] <= 4'h8
        |-> ##2 o_sport_enable && o_sport_mode == 4'($past(i_wdata, 2)))
        else $error("serial port mode wrong");
    ramp_pin_a: assert property (w_pin && i_wdata == rtpc_pkg::PF_PA_RAMP ##1 !w_pin
        |=> o_general_pin_zero == $past(i_pa_ramp_done)) else $error("ramp flag not on pin");
endmodule // rtpc_regs_sva

//--- rtpc_regs_tb_top.sv
// self-checking bench for the register bank
`timescale 1ns/1ns
module rtpc_regs_tb_top;
    logic i_mclk = 0, i_reset = 1, i_wr = 0, i_rd = 0, i_cal_done = 0;
    logic [9:0] i_addr = 10'h000;
    logic [7:0] i_wdata = 8'h00, i_cal_band = 8'h00, i_cal_ampl = 8'h00, o_rdata, band, ampl, d;
    logic [12:0] src = 13'h0000, h1, h2, h3;
    logic i_slicer_raw, i_lim_q, i_lim_i, i_lim_q_filt, i_lim_i_filt, i_tx_data, i_pa_ramp_done;
    logic i_test_dac, i_pin_default0, i_pin_default1, i_pin_default2, i_pin_default3;
    logic i_pin_default5, o_cal_enable, o_rssi_to_probe_pin, o_sport_enable, o_general_pin_zero;
    logic o_general_pin_one, o_general_pin_two, o_interrupt_shared_pin_three, o_general_pin_five;
    logic [2:0] o_crystal_tuning_code;
    logic [3:0] o_probe_gain, o_sport_mode;
    logic [1:0] o_tx_test_mode;
    logic [9:0] pe;
    integer seed = 32'h4D43874C, seed_src = 32'h1D2C3B4A, errors = 0, samples_checked = 0, cyc = 0;
    localparam logic [9:0] ADR [9] = '{rtpc_pkg::ADDR_TX_TEST_MODE, rtpc_pkg::ADDR_CAL_CTRL,
        rtpc_pkg::ADDR_XTAL_CFG, rtpc_pkg::ADDR_BAND_RES, rtpc_pkg::ADDR_AMPL_RES,
        rtpc_pkg::ADDR_PROBE_SEL, rtpc_pkg::ADDR_PROBE_MUX, rtpc_pkg::ADDR_PIN_FUNC,
        rtpc_pkg::ADDR_DAC_GAIN};
    localparam logic [7:0] RSV [9] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h04};
    localparam logic [7:0] MSK [9] = '{8'hFF, 8'h0F, 8'h38, 8'hFF, 8'hFF, 8'hFF, 8'h03, 8'hFF,
        8'h0F};
    localparam logic [7:0] PCODE [8] = '{8'h00, 8'h21, 8'h40, 8'h41, 8'h50, 8'h53, 8'hA9, 8'hC9};
    wire [4:0] pins = {o_general_pin_five, o_interrupt_shared_pin_three, o_general_pin_two,
        o_general_pin_one, o_general_pin_zero};
    assign {i_pin_default5, i_pin_default3, i_pin_default2, i_pin_default1, i_pin_default0,
        i_test_dac, i_pa_ramp_done, i_tx_data, i_lim_i_filt, i_lim_q_filt, i_lim_i, i_lim_q,
        i_slicer_raw} = src;
    rtpc_regs dut_u (.i_mclk, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_cal_done,
        .i_cal_band, .i_cal_ampl, .i_slicer_raw, .i_lim_q, .i_lim_i, .i_lim_q_filt, .i_lim_i_filt,
        .i_tx_data, .i_pa_ramp_done, .i_test_dac, .i_pin_default0, .i_pin_default1,
        .i_pin_default2, .i_pin_default3, .i_pin_default5, .o_cal_enable, .o_crystal_tuning_code,
        .o_rssi_to_probe_pin, .o_probe_gain, .o_tx_test_mode, .o_sport_enable, .o_sport_mode,
        .o_general_pin_zero, .o_general_pin_one, .o_general_pin_two,
        .o_interrupt_shared_pin_three, .o_general_pin_five);
    initial forever #5 i_mclk = ~i_mclk;
    // h1 is what the design sampled at this edge, h3 what the registered pins now present of the synchronised inputs
    always @(posedge i_mclk) begin
        src <= 13'($random(seed_src));
        h1 <= src;
        h2 <= h1;
        h3 <= h2;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors = errors + 1;
            end_of_test();
        end
    end
    task automatic end_of_test;
        if (errors == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] v);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [9:0] a, input logic [7:0] e);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1 chk(o_rdata, e);
    endtask
    task automatic reset_check;
        step(1);
        chk(o_cal_enable, 8'h01);
        chk(o_probe_gain, 8'h04);
        for (int i = 0; i < 9; i++) rd(ADR[i], RSV[i]);
    endtask
    // {mask, value} of all five pins for a pin function code
    function automatic logic [9:0] pin_exp(input logic [7:0] c, input logic [12:0] a, s);
        logic [4:0] v, m;
        v = a[12:8];
        m = 5'h1F;
        case (c)
            8'h21: v[4] = s[0];
            8'h40: v[1:0] = s[2:1];
            8'h41: v[3:0] = {s[2:1], s[4:3]};
            8'h50: v[0] = a[5];
            8'h53: v[0] = a[6];
            8'hC9: v[0] = a[7];
            default: ;
        endcase
        return {m, v & m};
    endfunction
    initial begin
        repeat (2) @(posedge i_mclk);
        i_reset <= 1'b0;
        reset_check();
        for (int k = 0; k < 3; k++) begin
            band = $random(seed);
            ampl = $random(seed);
            @(posedge i_mclk);
            i_cal_done <= 1'b1;
            i_cal_band <= band;
            i_cal_ampl <= ampl;
            @(posedge i_mclk);
            i_cal_done <= 1'b0;
            rd(rtpc_pkg::ADDR_BAND_RES, band);
            rd(rtpc_pkg::ADDR_AMPL_RES, ampl);
        end
        for (int n = 0; n < 4; n++) for (int i = 0; i < 9; i++) begin
            d = (n == 0) ? 8'hFF : 8'($random(seed));
            d = (i == 2) ? d & 8'h38 : d;
            wr(ADR[i], d);
            rd(ADR[i], i == 3 ? band : i == 4 ? ampl : d & MSK[i]);
        end
        for (int j = 0; j < 9; j++) begin
            d = (j == 0) ? 8'h0F : (j < 6) ? 8'(j - 1) : 8'($random(seed));
            wr(rtpc_pkg::ADDR_CAL_CTRL, d);
            wr(rtpc_pkg::ADDR_TX_TEST_MODE, d);
            step(1);
            chk(o_cal_enable, (d[3:0] != 4'hF) ? 8'h01 : 8'h00);
            chk(o_tx_test_mode, d == 0 ? 0 : d == 2 ? 1 : d == 3 ? 2 : 3);
        end
        for (int k = 0; k < 4; k++) begin
            wr(rtpc_pkg::ADDR_PROBE_SEL, k[0] ? 8'h64 : 8'h60);
            wr(rtpc_pkg::ADDR_PROBE_MUX, k[1] ? 8'hFF : 8'h01);
            step(1);
            chk(o_rssi_to_probe_pin, (k == 3) ? 8'h01 : 8'h00);
        end
        for (int j = 0; j < 17; j++) begin
            d = (j < 9) ? 8'hA0 + 8'(j) : PCODE[j-9];
            wr(rtpc_pkg::ADDR_PIN_FUNC, d);
            if (d == 8'hC9) wr(rtpc_pkg::ADDR_DAC_GAIN, 8'h00);
            step(3);
            chk({o_sport_enable, o_sport_mode}, j < 9 ? {1'b1, d[3:0]} : 5'h00);
            repeat (4) begin
                step(1);
                pe = pin_exp(d, h1, h3);
                chk(pins & pe[9:5], pe[4:0]);
            end
        end
        @(posedge i_mclk);
        i_reset <= 1'b1;
        repeat (2) @(posedge i_mclk);
        i_reset <= 1'b0;
        reset_check();
        rd(10'h3FF, 8'h00);
        step(2);
        end_of_test();
    end
endmodule // rtpc_regs_tb_top
bind rtpc_regs rtpc_regs_sva chk_u (.i_mclk, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_pa_ramp_done, .o_cal_enable, .o_crystal_tuning_code, .o_rssi_to_probe_pin, .o_probe_gain,
    .o_tx_test_mode, .o_sport_enable, .o_sport_mode, .o_general_pin_zero);
